// ### rtl/mol_limiter.sv
// thermal overload current limiter with ahb-lite register slave
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mol_limiter #(
    parameter int TICK_CYCLES = mol_pkg::CTRL_PERIOD_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [31:0] meas_current_ma,
    output logic [31:0] current_limit_ma,
    output logic overload_clamped,
    output logic irq
);
    import mol_pkg::*;

    // =================================================================
    // helpers
    function automatic logic [63:0] sq(input logic [31:0] v);
        return 64'(v) * 64'(v);
    endfunction

    function automatic logic [31:0] rd_mux(input mol_state_s st, input logic [7:0] a);
        logic [31:0] r;
        r = '0;
        case (a)
            OFF_SUBMODE: r = st.cfg.submode;
            OFF_MAX_MA: r = st.cfg.max_ma;
            OFF_RATED_MA: r = st.cfg.rated_ma;
            OFF_PEAK_PM: r = {16'h0, st.cfg.peak_pm};
            OFF_DUR_MS: r = st.cfg.dur_ms;
            OFF_THRESHOLD: r = st.thr_a2ms;
            OFF_ACCUM: r = st.acc_a2ms;
            OFF_LIMIT: r = st.limit;
            OFF_ACTIVE: r = {31'h0, st.mode != MOL_OFF};
            OFF_IRQ_STATUS: r = {29'h0, st.irq.status};
            OFF_IRQ_MASK: r = {29'h0, st.irq.mask};
            default: r = '0;
        endcase
        return r;
    endfunction

    // =================================================================
    // state
    mol_state_s s;
    mol_state_s n;
    logic tick;
    logic cond;
    logic addr_ok;
    logic [IRQ_W-1:0] w1c;
    logic [IRQ_W-1:0] ev;
    logic [47:0] peak_raw;
    logic [31:0] peak_eff;
    logic [63:0] rated_sq;
    logic [63:0] meas_sq;
    logic [ACC_W-1:0] thr_now;
    logic [ACC_W-1:0] delta;
    logic [ACC_W:0] sum;

    always_comb begin
        n = s;
        tick = (s.tick_cnt == 32'(TICK_CYCLES - 1));
        n.tick_cnt = tick ? '0 : s.tick_cnt + 32'h1;
        // register writes in the data phase
        n.dp_wr = 1'b0;
        if (s.dp_wr) begin
            case (s.dp_addr)
                OFF_SUBMODE: n.cfg.submode = hwdata;
                OFF_MAX_MA: n.cfg.max_ma = hwdata;
                OFF_RATED_MA: n.cfg.rated_ma = hwdata;
                OFF_PEAK_PM: n.cfg.peak_pm = hwdata[15:0];
                OFF_DUR_MS: n.cfg.dur_ms = hwdata;
                OFF_IRQ_MASK: n.irq.mask = hwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        w1c = '0;
        if (s.dp_wr && s.dp_addr == OFF_IRQ_STATUS) begin
            w1c = hwdata[IRQ_W-1:0];
        end
        // peak in ma from permille of rated, capped at the motor maximum
        peak_raw = 48'(s.cfg.rated_ma) * 48'(s.cfg.peak_pm) / PERMILLE_FULL;
        peak_eff = (peak_raw > 48'(s.cfg.max_ma)) ? s.cfg.max_ma : peak_raw[31:0];
        n.peak_ma = peak_eff;
        cond = s.cfg.submode[SUBMODE_CLOSED_BIT]
            && (peak_eff > s.cfg.rated_ma)
            && (s.cfg.dur_ms != 32'h0);
        rated_sq = sq(s.cfg.rated_ma);
        meas_sq = sq(meas_current_ma);
        // threshold in ma^2*us, no rounding
        thr_now = ACC_W'(sq(peak_eff) - rated_sq) * ACC_W'(s.cfg.dur_ms) * US_PER_MS;
        n.thr = thr_now;
        // heat integration once per control period
        delta = '0;
        sum = '0;
        if (tick && cond) begin
            if (meas_current_ma > s.cfg.rated_ma) begin
                delta = ACC_W'(meas_sq - rated_sq) * ACC_W'(CTRL_PERIOD_US);
                sum = {1'b0, s.acc} + {1'b0, delta};
                n.acc = sum[ACC_W] ? '1 : sum[ACC_W-1:0];
            end else begin
                delta = ACC_W'(rated_sq - meas_sq) * ACC_W'(CTRL_PERIOD_US);
                n.acc = (delta > s.acc) ? '0 : s.acc - delta;
            end
        end
        // mode: off, peak allowed, clamped to rated; heat kept across modes
        case (s.mode)
            MOL_OFF: begin
                if (cond) begin
                    n.mode = (n.acc >= thr_now) ? MOL_RATED : MOL_PEAK;
                end
            end
            MOL_PEAK: begin
                if (!cond) begin
                    n.mode = MOL_OFF;
                end else if (n.acc >= thr_now) begin
                    n.mode = MOL_RATED;
                end
            end
            MOL_RATED: begin
                if (!cond) begin
                    n.mode = MOL_OFF;
                end else if (n.acc < thr_now) begin
                    n.mode = MOL_PEAK;
                end
            end
            default: n.mode = MOL_OFF;
        endcase
        case (n.mode)
            MOL_RATED: n.limit = s.cfg.rated_ma;
            MOL_PEAK: n.limit = peak_eff;
            default: n.limit = s.cfg.max_ma;
        endcase
        n.thr_a2ms = 32'(s.thr / MA2US_PER_A2MS);
        n.acc_a2ms = 32'(s.acc / MA2US_PER_A2MS);
        // sticky events, set beats clear
        ev = '0;
        ev[IRQ_CLAMP_BIT] = (n.mode == MOL_RATED) && (s.mode != MOL_RATED);
        ev[IRQ_RELEASE_BIT] = (s.mode == MOL_RATED) && (n.mode != MOL_RATED);
        ev[IRQ_ACTIVE_BIT] = (n.mode == MOL_OFF) != (s.mode == MOL_OFF);
        n.irq.status = (s.irq.status & ~w1c) | ev;
        // address phase; reads see this cycle's write
        addr_ok = (haddr[31:ADDR_W] == '0);
        if (hsel && hready && htrans[1]) begin
            n.dp_wr = hwrite && addr_ok && (hsize == HSIZE_WORD);
            n.dp_addr = haddr[7:0];
            if (!hwrite) begin
                n.hrdata = addr_ok ? rd_mux(n, haddr[7:0]) : 32'h0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= STATE_RESET;
        end else begin
            s <= n;
        end
    end

    // =================================================================
    // outputs
    assign hrdata = s.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign current_limit_ma = s.limit;
    assign overload_clamped = (s.mode == MOL_RATED);
    assign irq = |(s.irq.status & s.irq.mask);

    // =================================================================
    // assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rd_flag;
        hsel && hready && htrans[1] && !hwrite && haddr == 32'(OFF_ACTIVE);
    endsequence
    sequence s_open_loop;
        !s.cfg.submode[SUBMODE_CLOSED_BIT];
    endsequence
    sequence s_over_limit;
        s.mode != MOL_OFF && cond && n.acc >= thr_now;
    endsequence

    open_loop_off_a: assert property (s_open_loop |=> s.mode == MOL_OFF)
        else $error("protection active outside closed loop");
    peak_cond_a: assert property ((s.cfg.peak_pm <= 16'h3e8 || s.cfg.dur_ms == 32'h0)
        |=> s.mode == MOL_OFF)
        else $error("protection active without valid peak setup");
    no_limit_off_a: assert property (!cond |=> s.limit == $past(s.cfg.max_ma))
        else $error("limiting applied while disabled");
    clamp_rated_a: assert property (s_over_limit |=> overload_clamped
        && current_limit_ma == $past(s.cfg.rated_ma))
        else $error("limit not clamped to rated at once");
    max_cap_a: assert property (##1 s.limit <= $past(s.cfg.max_ma))
        else $error("applied limit above motor maximum");
    clamp_choice_a: assert property (s.mode != MOL_OFF |-> overload_clamped
        == (s.acc >= s.thr))
        else $error("clamp disagrees with heat compare");
    flag_read_a: assert property (s_rd_flag |=> hrdata == {31'h0, s.mode != MOL_OFF})
        else $error("activity flag read wrong");
    heat_rise_a: assert property (tick && cond && meas_current_ma > s.cfg.rated_ma
        && !(&s.acc) |=> s.acc > $past(s.acc))
        else $error("heat did not rise above rated");
    heat_kept_a: assert property (!tick |=> s.acc == $past(s.acc))
        else $error("heat changed between periods");
    irq_set_wins_a: assert property (ev[IRQ_CLAMP_BIT] && w1c[IRQ_CLAMP_BIT]
        |=> s.irq.status[IRQ_CLAMP_BIT])
        else $error("event lost under clear");
    thr_formula_a: assert property (##1 s.thr == ACC_W'(sq($past(peak_eff))
        - sq($past(s.cfg.rated_ma))) * ACC_W'($past(s.cfg.dur_ms)) * US_PER_MS)
        else $error("threshold formula wrong");

    // =================================================================
    // bus response checks
    sequence s_rd_take;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence s_wr_take;
        hsel && hready && htrans[1] && hwrite;
    endsequence

    ready_always_a: assert property (hreadyout)
        else $error("slave inserted a wait state");
    resp_okay_a: assert property (!hresp)
        else $error("slave answered with an error");
    rd_unmapped_a: assert property (s_rd_take ##0 haddr[31:ADDR_W] != '0
        |=> hrdata == 32'h0)
        else $error("unmapped read returned data");
    rd_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite)
        |=> $stable(hrdata))
        else $error("read data moved without a read");
    // reads return the value registered at the address edge
    rd_limit_a: assert property (s_rd_take ##0 haddr == 32'(OFF_LIMIT)
        |=> hrdata == s.limit)
        else $error("applied limit read wrong");
    rd_thr_a: assert property (s_rd_take ##0 haddr == 32'(OFF_THRESHOLD)
        |=> hrdata == s.thr_a2ms)
        else $error("threshold read wrong");
    rd_acc_a: assert property (s_rd_take ##0 haddr == 32'(OFF_ACCUM)
        |=> hrdata == s.acc_a2ms)
        else $error("heat value read wrong");
    rd_max_a: assert property (s_rd_take ##0 haddr == 32'(OFF_MAX_MA)
        |=> hrdata == s.cfg.max_ma)
        else $error("maximum current read wrong");
    rd_status_a: assert property (s_rd_take ##0 haddr == 32'(OFF_IRQ_STATUS)
        |=> hrdata == {29'h0, s.irq.status})
        else $error("interrupt status read wrong");
    wr_narrow_a: assert property (s_wr_take ##0 hsize != HSIZE_WORD |=> !s.dp_wr)
        else $error("narrow write accepted");
    wr_unmapped_a: assert property (s_wr_take ##0 haddr[31:ADDR_W] != '0 |=> !s.dp_wr)
        else $error("unmapped write accepted");
    wr_good_a: assert property (s_wr_take ##0 hsize == HSIZE_WORD
        ##0 haddr[31:ADDR_W] == '0 |=> s.dp_wr && s.dp_addr == $past(haddr[7:0]))
        else $error("word write not carried to its data phase");
    wr_max_a: assert property (s.dp_wr && s.dp_addr == OFF_MAX_MA
        |=> s.cfg.max_ma == $past(hwdata))
        else $error("maximum current write lost");
    wr_rated_a: assert property (s.dp_wr && s.dp_addr == OFF_RATED_MA
        |=> s.cfg.rated_ma == $past(hwdata))
        else $error("rated current write lost");
    wr_peak_a: assert property (s.dp_wr && s.dp_addr == OFF_PEAK_PM
        |=> s.cfg.peak_pm == $past(hwdata[15:0]))
        else $error("peak setting write lost");
    wr_dur_a: assert property (s.dp_wr && s.dp_addr == OFF_DUR_MS
        |=> s.cfg.dur_ms == $past(hwdata))
        else $error("peak duration write lost");
    wr_mode_a: assert property (s.dp_wr && s.dp_addr == OFF_SUBMODE
        |=> s.cfg.submode == $past(hwdata))
        else $error("submode write lost");
    wr_mask_a: assert property (s.dp_wr && s.dp_addr == OFF_IRQ_MASK
        |=> s.irq.mask == $past(hwdata[IRQ_W-1:0]))
        else $error("interrupt mask write lost");
    ro_thr_a: assert property (s.dp_wr && s.dp_addr == OFF_THRESHOLD
        |=> s.cfg == $past(s.cfg))
        else $error("read-only threshold changed settings");

    // =================================================================
    // limit value checks
    sequence s_now_off;
        1'b1 ##1 s.mode == MOL_OFF;
    endsequence
    sequence s_now_peak;
        1'b1 ##1 s.mode == MOL_PEAK;
    endsequence
    sequence s_now_rated;
        1'b1 ##1 s.mode == MOL_RATED;
    endsequence

    off_limit_a: assert property (s_now_off |-> s.limit == $past(s.cfg.max_ma))
        else $error("inactive limit is not the motor maximum");
    peak_limit_a: assert property (s_now_peak |-> s.limit == $past(peak_eff))
        else $error("unclamped limit is not the peak current");
    rated_limit_a: assert property (s_now_rated |-> s.limit == $past(s.cfg.rated_ma))
        else $error("clamped limit is not the rated current");
    peak_cap_a: assert property (##1 s.peak_ma <= $past(s.cfg.max_ma))
        else $error("effective peak above motor maximum");
    peak_unity_a: assert property (s.cfg.peak_pm == 16'h3e8 && s.cfg.rated_ma <= s.cfg.max_ma
        |=> s.peak_ma == $past(s.cfg.rated_ma))
        else $error("full scale peak differs from rated");
    peak_double_a: assert property (s.cfg.peak_pm == 16'h7d0
        && {1'b0, s.cfg.rated_ma, 1'b0} <= {2'b0, s.cfg.max_ma}
        |=> s.peak_ma == {$past(s.cfg.rated_ma[30:0]), 1'b0})
        else $error("double scale peak wrong");

    // =================================================================
    // activation checks
    dur_zero_off_a: assert property (s.cfg.dur_ms == 32'h0 |=> s.mode == MOL_OFF)
        else $error("active with zero peak duration");
    peak_low_off_a: assert property (peak_eff <= s.cfg.rated_ma |=> s.mode == MOL_OFF)
        else $error("active with peak not above rated");
    cond_on_a: assert property (cond |=> s.mode != MOL_OFF)
        else $error("inactive although conditions hold");
    on_needs_cond_a: assert property ((1'b1 ##1 s.mode != MOL_OFF) |-> $past(cond))
        else $error("active without its conditions");
    mode_legal_a: assert property (s.mode inside {MOL_OFF, MOL_PEAK, MOL_RATED})
        else $error("illegal protection mode");
    release_a: assert property (s.mode == MOL_RATED && cond && n.acc < thr_now
        |=> s.mode == MOL_PEAK)
        else $error("clamp not released below threshold");
    peak_hold_a: assert property (s.mode == MOL_PEAK && cond && n.acc < thr_now
        |=> s.mode == MOL_PEAK && !overload_clamped)
        else $error("clamped below threshold");

    // =================================================================
    // heat checks
    heat_off_hold_a: assert property (!cond |=> s.acc == $past(s.acc))
        else $error("heat changed while inactive");
    heat_fall_a: assert property (tick && cond && meas_current_ma < s.cfg.rated_ma
        && s.acc != '0 |=> s.acc < $past(s.acc))
        else $error("heat did not fall below rated");
    heat_flat_a: assert property (tick && cond && meas_current_ma == s.cfg.rated_ma
        |=> s.acc == $past(s.acc))
        else $error("heat moved at rated current");
    heat_sat_a: assert property (tick && cond && meas_current_ma > s.cfg.rated_ma
        && (&s.acc) |=> &s.acc)
        else $error("heat wrapped instead of saturating");
    tick_wrap_a: assert property (tick |=> s.tick_cnt == 32'h0)
        else $error("period counter did not wrap");
    tick_step_a: assert property (!tick |=> s.tick_cnt == $past(s.tick_cnt) + 32'h1)
        else $error("period counter did not step");
    thr_read_a: assert property (##1 s.thr_a2ms
        == 32'($past(s.thr) / MA2US_PER_A2MS))
        else $error("threshold scaling wrong");
    acc_read_a: assert property (##1 s.acc_a2ms
        == 32'($past(s.acc) / MA2US_PER_A2MS))
        else $error("heat value scaling wrong");

    // =================================================================
    // interrupt checks
    irq_clamp_ev_a: assert property ((s.mode != MOL_RATED ##1 s.mode == MOL_RATED)
        |-> s.irq.status[IRQ_CLAMP_BIT])
        else $error("clamp event not recorded");
    irq_rel_ev_a: assert property ((s.mode == MOL_RATED ##1 s.mode != MOL_RATED)
        |-> s.irq.status[IRQ_RELEASE_BIT])
        else $error("release event not recorded");
    irq_act_ev_a: assert property ((s.mode == MOL_OFF ##1 s.mode != MOL_OFF)
        |-> s.irq.status[IRQ_ACTIVE_BIT])
        else $error("activation event not recorded");
    irq_sticky_a: assert property (s.irq.status[IRQ_CLAMP_BIT] && !w1c[IRQ_CLAMP_BIT]
        |=> s.irq.status[IRQ_CLAMP_BIT])
        else $error("status bit dropped without clear");
    irq_clear_a: assert property (w1c[IRQ_RELEASE_BIT] && !ev[IRQ_RELEASE_BIT]
        |=> !s.irq.status[IRQ_RELEASE_BIT])
        else $error("status bit not cleared by write");
    irq_mask_a: assert property (!(|s.irq.mask) |-> !irq)
        else $error("interrupt raised while fully masked");
endmodule
`default_nettype wire

// ### rtl/mol_pkg.sv
// package: register map, constants and state types of the overload limiter
// =====================================================================
package mol_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_SUBMODE = 8'h00;
    localparam logic [7:0] OFF_MAX_MA = 8'h04;
    localparam logic [7:0] OFF_RATED_MA = 8'h08;
    localparam logic [7:0] OFF_PEAK_PM = 8'h0c;
    localparam logic [7:0] OFF_DUR_MS = 8'h10;
    localparam logic [7:0] OFF_THRESHOLD = 8'h14;
    localparam logic [7:0] OFF_ACCUM = 8'h18;
    localparam logic [7:0] OFF_LIMIT = 8'h1c;
    localparam logic [7:0] OFF_ACTIVE = 8'h20;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
    localparam int SUBMODE_CLOSED_BIT = 0;
    localparam int IRQ_W = 3;
    localparam int IRQ_CLAMP_BIT = 0;
    localparam int IRQ_RELEASE_BIT = 1;
    localparam int IRQ_ACTIVE_BIT = 2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [47:0] PERMILLE_FULL = 48'h3e8;
    localparam int ACC_W = 112;
    localparam logic [ACC_W-1:0] US_PER_MS = 112'h3e8;
    localparam logic [ACC_W-1:0] MA2US_PER_A2MS = 112'h3b9a_ca00;
    localparam int CLK_MHZ = 20;
    localparam int CTRL_PERIOD_US = 1000;
    localparam int CTRL_PERIOD_CYCLES = CLK_MHZ * CTRL_PERIOD_US;
    typedef enum logic [1:0] {MOL_OFF, MOL_PEAK, MOL_RATED} mol_mode_e;
    typedef struct packed {
        logic [31:0] submode;
        logic [31:0] max_ma;
        logic [31:0] rated_ma;
        logic [15:0] peak_pm;
        logic [31:0] dur_ms;
    } mol_cfg_s;
    typedef struct packed {
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
    } mol_irq_s;
    typedef struct packed {
        mol_cfg_s cfg;
        mol_irq_s irq;
        mol_mode_e mode;
        logic [ACC_W-1:0] acc;
        logic [ACC_W-1:0] thr;
        logic [31:0] peak_ma;
        logic [31:0] limit;
        logic [31:0] thr_a2ms;
        logic [31:0] acc_a2ms;
        logic [31:0] tick_cnt;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
    } mol_state_s;
    localparam mol_state_s STATE_RESET = '0;
endpackage

// ### test/mol_ctrl_model.sv
// model of the drive's closed-loop current controller
`timescale 1ns/1ps
`default_nettype none
module mol_ctrl_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] demand_ma,
    input wire logic [31:0] current_limit_ma,
    output logic [31:0] meas_current_ma
);
    // ==========================================
    // motor current follows demand, capped by the limit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meas_current_ma <= 32'h0;
        end else begin
            meas_current_ma <= (demand_ma < current_limit_ma) ? demand_ma : current_limit_ma;
        end
    end
endmodule
`default_nettype wire

// ### test/test_motor_current_overload_limiter.sv
// testbench of the overload limiter
`timescale 1ns/1ps
`default_nettype none
module test_motor_current_overload_limiter;
    import mol_pkg::*;
    localparam int TK = 20;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] demand_ma = 32'h0;
    logic [31:0] hrdata, current_limit_ma, meas_current_ma, rd;
    logic hreadyout, hresp, overload_clamped, irq;
    logic [31:0] pm [3] = '{32'h3e8, 32'h7d0, 32'h1f4};
    logic [31:0] du [3] = '{32'h5, 32'h0, 32'h5};
    int n_errors = 0;
    int comparisons = 0;
    int n1, n2;
    mol_limiter #(.TICK_CYCLES(TK)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .meas_current_ma(meas_current_ma), .current_limit_ma(current_limit_ma),
        .overload_clamped(overload_clamped), .irq(irq));
    mol_ctrl_model ctrl (.hclk(hclk), .hresetn(hresetn), .demand_ma(demand_ma),
        .current_limit_ma(current_limit_ma), .meas_current_ma(meas_current_ma));
    initial begin
        forever #25 hclk = ~hclk;
    end
    // ==========================================
    // bus and check tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic wait_lvl(input logic v, output int n);
        n = 0;
        #1;
        while (overload_clamped !== v && n < 400) begin
            @(posedge hclk);
            #1;
            n++;
        end
        if (n >= 400) begin
            n_errors++;
        end
        @(posedge hclk);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge hclk);
        n_errors++;
        print_verdict();
    end
    // ==========================================
    // scenarios
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(OFF_LIMIT, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        rdc(8'h40, 32'h0);
        wr(OFF_THRESHOLD, 32'h55);
        rdc(OFF_THRESHOLD, 32'h0);
        wr(OFF_MAX_MA, 32'h1388);
        wr(OFF_RATED_MA, 32'h3e8);
        wr(OFF_PEAK_PM, 32'h7d0);
        wr(OFF_DUR_MS, 32'h5);
        wr(OFF_SUBMODE, 32'h2);
        rdc(OFF_ACTIVE, 32'h0);
        rdc(OFF_LIMIT, 32'h1388);
        rdc(OFF_RATED_MA, 32'h3e8);
        wr(OFF_SUBMODE, 32'h1);
        rdc(OFF_ACTIVE, 32'h1);
        rdc(OFF_LIMIT, 32'h7d0);
        rdc(OFF_THRESHOLD, 32'hf);
        wr(OFF_IRQ_MASK, 32'h7);
        wr(OFF_IRQ_STATUS, 32'h7);
        demand_ma <= 32'hbb8;
        wait_lvl(1'b1, n1);
        chk(current_limit_ma, 32'h3e8);
        chk({31'h0, irq}, 32'h1);
        chk(32'(n1 > 4 * TK && n1 <= 6 * TK), 32'h1);
        rdc(OFF_ACCUM, 32'hf);
        rdc(OFF_IRQ_STATUS, 32'h1);
        wr(OFF_IRQ_MASK, 32'h0);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_IRQ_STATUS, 32'h1);
        rdc(OFF_IRQ_STATUS, 32'h0);
        demand_ma <= 32'h1f4;
        wait_lvl(1'b0, n2);
        chk(current_limit_ma, 32'h7d0);
        rdc(OFF_IRQ_STATUS, 32'h2);
        repeat (2 * TK) @(posedge hclk);
        demand_ma <= 32'hbb8;
        wait_lvl(1'b1, n2);
        chk(32'(n2 < n1), 32'h1);
        demand_ma <= 32'h0;
        for (int i = 0; i < 3; i++) begin
            wr(OFF_PEAK_PM, pm[i]);
            wr(OFF_DUR_MS, du[i]);
            rdc(OFF_ACTIVE, 32'h0);
            rdc(OFF_LIMIT, 32'h1388);
        end
        wr(OFF_PEAK_PM, 32'h2328);
        rdc(OFF_ACTIVE, 32'h1);
        rdc(OFF_LIMIT, 32'h1388);
        chk(current_limit_ma, 32'h1388);
        print_verdict();
    end
endmodule
`default_nettype wire
